// ### core/rsc_pkg.sv
`default_nettype none

package rsc_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam logic [11:0] OFS_PART_ID = 12'h000;
    localparam logic [11:0] OFS_CAUSE = 12'h004;
    localparam logic [11:0] OFS_CORE_CTL = 12'h008;
    localparam logic [11:0] OFS_PERIPH_CTL = 12'h00c;
    localparam logic [11:0] OFS_UNLOCK = 12'h100;

    // ------------------------------------------------------------
    // Field layouts and reset values
    // ------------------------------------------------------------
    localparam int CAUSE_POWER_ON = 0;
    localparam int CAUSE_EXT_PIN = 1;
    localparam int CAUSE_WATCHDOG = 2;
    localparam int CAUSE_LOW_VOLTAGE = 3;
    localparam int CAUSE_BROWNOUT = 4;
    localparam int CAUSE_CORE_SYS_REQUEST = 5;
    localparam int CAUSE_CPU_ONESHOT = 7;
    localparam logic [7:0] CAUSE_MASK = 8'hbf;
    localparam logic [7:0] CAUSE_RESET = 8'h01;

    localparam int CORE_CHIP_ONESHOT = 0;
    localparam int CORE_CPU_ONESHOT = 1;
    localparam int CORE_PERIPH_DMA = 2;
    localparam int CORE_EXT_BUS_IF = 3;
    localparam logic [3:0] CORE_RESET = 4'h0;

    localparam int PERIPH_GPIO = 1;
    localparam int PERIPH_TIMER_ZERO = 2;
    localparam int PERIPH_TIMER_THREE = 5;
    localparam int PERIPH_KBD_MOUSE_PORT = 23;
    localparam int PERIPH_CAN_CTRL = 24;
    localparam int PERIPH_USB_DEVICE = 27;
    localparam int PERIPH_ADC = 28;
    localparam int PERIPH_I2S = 29;
    localparam logic [31:0] PERIPH_MASK = 32'h39f7_f33e;
    localparam logic [31:0] PERIPH_RESET = 32'h0000_0000;

    // ------------------------------------------------------------
    // Unlock sequence
    // ------------------------------------------------------------
    localparam logic [7:0] UNLOCK_KEY0 = 8'h59;
    localparam logic [7:0] UNLOCK_KEY1 = 8'h16;
    localparam logic [7:0] UNLOCK_KEY2 = 8'h88;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int ONESHOT_CYCLES = 2;
    localparam logic [1:0] ONESHOT_LOAD = 2'(ONESHOT_CYCLES);

    // ------------------------------------------------------------
    // Bus answers
    // ------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum {
        SEL_PART_ID,
        SEL_CAUSE,
        SEL_CORE_CTL,
        SEL_PERIPH_CTL,
        SEL_UNLOCK,
        SEL_NONE
    } rsc_sel_type;

endpackage

`default_nettype wire

// ### core/rsc_reset_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

module rsc_reset_ctrl
    import rsc_pkg::*;
#(
    // Arbitrary neutral identification value
    parameter logic [31:0] PART_ID = 32'h0000_a5c3
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [rsc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [rsc_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic ext_pin_reset_n,
    input wire logic watchdog_reset,
    input wire logic low_voltage_reset,
    input wire logic brownout_reset,
    input wire logic core_sys_reset_request,
    output logic system_reset,
    output logic xtal_boot_reset,
    output logic chip_oneshot_reset,
    output logic cpu_flash_reset,
    output logic ext_bus_if_reset,
    output logic periph_dma_reset,
    output logic [31:0] periph_reset
);
    import rsc_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic awready;
        logic wready;
        logic [ADDR_W-1:0] waddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [7:0] cause;
        logic [3:0] core_ctl;
        logic [1:0] shot_cnt;
        logic [31:0] periph;
        logic [1:0] unlock_stage;
        logic unlocked;
        logic pin_meta;
        logic pin_sync;
        logic sys_rst;
        logic xtal_rst;
    } rsc_state_type;

    // Synchroniser stages start at the idle pin level, so that leaving
    // reset does not log a false pin cause.
    localparam rsc_state_type STATE_RESET = '{
        awready: 1'b1,
        wready: 1'b1,
        waddr: '0,
        wdata: '0,
        wstrb: '0,
        bvalid: 1'b0,
        bresp: RESP_OKAY,
        arready: 1'b1,
        rvalid: 1'b0,
        rresp: RESP_OKAY,
        rdata: '0,
        cause: CAUSE_RESET,
        core_ctl: CORE_RESET,
        shot_cnt: 2'h0,
        periph: PERIPH_RESET,
        unlock_stage: 2'h0,
        unlocked: 1'b0,
        pin_meta: 1'b1,
        pin_sync: 1'b1,
        sys_rst: 1'b1,
        xtal_rst: 1'b1
    };

    rsc_state_type state_reg;
    rsc_state_type state_next;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic rsc_sel_type decode(input logic [ADDR_W-1:0] addr);
        rsc_sel_type sel;
        sel = SEL_NONE;
        unique case (addr)
            OFS_PART_ID: sel = SEL_PART_ID;
            OFS_CAUSE: sel = SEL_CAUSE;
            OFS_CORE_CTL: sel = SEL_CORE_CTL;
            OFS_PERIPH_CTL: sel = SEL_PERIPH_CTL;
            OFS_UNLOCK: sel = SEL_UNLOCK;
            default: sel = SEL_NONE;
        endcase
        return sel;
    endfunction

    function automatic logic [31:0] strobe_mask(input logic [3:0] strb);
        logic [31:0] m;
        m = '0;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = {8{strb[i]}};
        end
        return m;
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        rsc_state_type n;
        logic do_write;
        logic [31:0] wmask;
        logic [31:0] wval;
        logic [7:0] cause_set;
        logic [7:0] cause_clr;
        rsc_sel_type wsel;
        rsc_sel_type rsel;

        n = state_reg;
        do_write = !state_reg.awready && !state_reg.wready && !state_reg.bvalid;
        wmask = strobe_mask(state_reg.wstrb);
        wval = state_reg.wdata & wmask;
        wsel = decode(state_reg.waddr);
        rsel = decode(s_axi_araddr);
        cause_set = '0;
        cause_clr = '0;

        // ------------------------------------------------------------
        // Reset sources
        // ------------------------------------------------------------
        // Pin is asynchronous; first stage feeds only the second
        n.pin_meta = ext_pin_reset_n;
        n.pin_sync = state_reg.pin_meta;

        cause_set[CAUSE_WATCHDOG] = watchdog_reset;
        cause_set[CAUSE_LOW_VOLTAGE] = low_voltage_reset;
        cause_set[CAUSE_BROWNOUT] = brownout_reset;
        cause_set[CAUSE_CORE_SYS_REQUEST] = core_sys_reset_request;
        cause_set[CAUSE_EXT_PIN] = !state_reg.pin_sync;

        // ------------------------------------------------------------
        // One-shot pulses
        // ------------------------------------------------------------
        // One counter times both shot bits: a second shot restarts the
        // window for both, traded against a second counter.
        // One-shot bits drop by themselves after the pulse width
        if (state_reg.shot_cnt != 2'h0) begin
            n.shot_cnt = state_reg.shot_cnt - 2'h1;
            if (state_reg.shot_cnt == 2'h1) begin
                n.core_ctl[CORE_CPU_ONESHOT] = 1'b0;
                n.core_ctl[CORE_CHIP_ONESHOT] = 1'b0;
            end
        end

        // ------------------------------------------------------------
        // Write channel
        // ------------------------------------------------------------
        // Write address and data are taken independently
        if (s_axi_awvalid && state_reg.awready) begin
            n.awready = 1'b0;
            n.waddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && state_reg.wready) begin
            n.wready = 1'b0;
            n.wdata = s_axi_wdata;
            n.wstrb = s_axi_wstrb;
        end

        // ------------------------------------------------------------
        // Register writes
        // ------------------------------------------------------------
        if (do_write) begin
            n.bvalid = 1'b1;
            n.bresp = (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
            unique case (wsel)
                SEL_CAUSE: begin
                    cause_clr = wval[7:0] & CAUSE_MASK;
                end
                SEL_CORE_CTL: begin
                    if (state_reg.unlocked) begin
                        if (wmask[CORE_EXT_BUS_IF]) begin
                            n.core_ctl[CORE_EXT_BUS_IF] = wval[CORE_EXT_BUS_IF];
                        end
                        if (wmask[CORE_PERIPH_DMA]) begin
                            n.core_ctl[CORE_PERIPH_DMA] = wval[CORE_PERIPH_DMA];
                        end
                        if (wval[CORE_CPU_ONESHOT]) begin
                            n.core_ctl[CORE_CPU_ONESHOT] = 1'b1;
                            n.shot_cnt = ONESHOT_LOAD;
                            cause_set[CAUSE_CPU_ONESHOT] = 1'b1;
                        end
                        if (wval[CORE_CHIP_ONESHOT]) begin
                            n.core_ctl[CORE_CHIP_ONESHOT] = 1'b1;
                            n.shot_cnt = ONESHOT_LOAD;
                            cause_set[CAUSE_POWER_ON] = 1'b1;
                        end
                    end
                end
                SEL_PERIPH_CTL: begin
                    n.periph = ((state_reg.periph & ~wmask) | wval) & PERIPH_MASK;
                end
                SEL_UNLOCK: begin
                    // Any write here while open closes the lock again, so a
                    // stray write cannot leave the protected bits exposed.
                    // unlock key sequence
                    n.unlock_stage = 2'h0;
                    n.unlocked = 1'b0;
                    if (!state_reg.unlocked && state_reg.wstrb[0]) begin
                        if (state_reg.unlock_stage == 2'h2 && wval[7:0] == UNLOCK_KEY2) begin
                            n.unlocked = 1'b1;
                        end else if (state_reg.unlock_stage == 2'h1
                                     && wval[7:0] == UNLOCK_KEY1) begin
                            n.unlock_stage = 2'h2;
                        end else if (wval[7:0] == UNLOCK_KEY0) begin
                            n.unlock_stage = 2'h1;
                        end
                    end
                end
                SEL_PART_ID, SEL_NONE: begin
                    n.bvalid = 1'b1;
                end
            endcase
        end

        // ------------------------------------------------------------
        // Write answer
        // ------------------------------------------------------------
        if (state_reg.bvalid && s_axi_bready) begin
            n.bvalid = 1'b0;
            n.awready = 1'b1;
            n.wready = 1'b1;
        end

        // ------------------------------------------------------------
        // Read channel
        // ------------------------------------------------------------
        // Read path: one read outstanding, data latched at acceptance
        if (s_axi_arvalid && state_reg.arready) begin
            n.arready = 1'b0;
            n.rvalid = 1'b1;
            n.rresp = RESP_OKAY;
            unique case (rsel)
                SEL_PART_ID: n.rdata = PART_ID;
                SEL_CAUSE: n.rdata = {24'h00_0000, state_reg.cause};
                SEL_CORE_CTL: n.rdata = {28'h000_0000, state_reg.core_ctl};
                SEL_PERIPH_CTL: n.rdata = state_reg.periph;
                SEL_UNLOCK: n.rdata = {31'h0000_0000, state_reg.unlocked};
                SEL_NONE: begin
                    n.rdata = 32'h0000_0000;
                    n.rresp = RESP_SLVERR;
                end
            endcase
        end
        if (state_reg.rvalid && s_axi_rready) begin
            n.rvalid = 1'b0;
            n.arready = 1'b1;
        end

        // ------------------------------------------------------------
        // Cause flags and reset outputs
        // ------------------------------------------------------------
        // Set wins over a clear arriving in the same cycle
        n.cause = ((state_reg.cause & ~cause_clr) | cause_set) & CAUSE_MASK;

        n.xtal_rst = state_reg.core_ctl[CORE_CHIP_ONESHOT];
        // The CPU shot stays out: it reaches only core and flash over
        // its own output, and the rest of the chip keeps running.
        n.sys_rst = |cause_set[CAUSE_CORE_SYS_REQUEST:CAUSE_EXT_PIN]
                    || state_reg.core_ctl[CORE_CHIP_ONESHOT];

        state_next = n;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // cause flags kept
    // Only rst_n (power-on) clears this block; the system resets it
    // produces never loop back here, so recorded causes persist.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_reg <= STATE_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign s_axi_awready = state_reg.awready;
    assign s_axi_wready = state_reg.wready;
    assign s_axi_bvalid = state_reg.bvalid;
    assign s_axi_bresp = state_reg.bresp;
    assign s_axi_arready = state_reg.arready;
    assign s_axi_rvalid = state_reg.rvalid;
    assign s_axi_rresp = state_reg.rresp;
    assign s_axi_rdata = state_reg.rdata;
    assign system_reset = state_reg.sys_rst;
    assign xtal_boot_reset = state_reg.xtal_rst;
    assign chip_oneshot_reset = state_reg.core_ctl[CORE_CHIP_ONESHOT];
    assign cpu_flash_reset = state_reg.core_ctl[CORE_CPU_ONESHOT];
    assign ext_bus_if_reset = state_reg.core_ctl[CORE_EXT_BUS_IF];
    assign periph_dma_reset = state_reg.core_ctl[CORE_PERIPH_DMA];
    assign periph_reset = state_reg.periph;

endmodule // rsc_reset_ctrl

`default_nettype wire

// ### testbench/rsc_reset_ctrl_assertions.sv
`timescale 1ns/1ps
`default_nettype none

module rsc_reset_ctrl_assertions (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic watchdog_reset,
    input wire logic system_reset,
    input wire logic xtal_boot_reset,
    input wire logic chip_oneshot_reset,
    input wire logic cpu_flash_reset
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    // ------------------------------------------------------------
    // Bus answers
    // ------------------------------------------------------------
    chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid) else $error("write answer late");
    chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
    chk_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("second read taken early");

    // ------------------------------------------------------------
    // Reset outputs
    // ------------------------------------------------------------
    chk_cpu_shot: assert property ($rose(cpu_flash_reset)
        |-> cpu_flash_reset [*2] ##1 !cpu_flash_reset) else $error("cpu pulse length");
    chk_chip_shot: assert property ($rose(chip_oneshot_reset)
        |-> chip_oneshot_reset [*2] ##1 !chip_oneshot_reset) else $error("chip pulse length");
    chk_chip_system: assert property (chip_oneshot_reset
        |=> system_reset && xtal_boot_reset) else $error("chip shot not reset");
    chk_wdt_system: assert property (watchdog_reset |=> system_reset)
        else $error("watchdog not reset");
    chk_xtal_spared: assert property (rst_n && !chip_oneshot_reset |=> !xtal_boot_reset)
        else $error("crystal reset without cause");

    cover property ($rose(cpu_flash_reset));
    cover property ($rose(chip_oneshot_reset));
    cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule // rsc_reset_ctrl_assertions

bind rsc_reset_ctrl rsc_reset_ctrl_assertions i_rsc_reset_ctrl_assertions (
    .clock(clock), .rst_n(rst_n), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .watchdog_reset(watchdog_reset),
    .system_reset(system_reset), .xtal_boot_reset(xtal_boot_reset),
    .chip_oneshot_reset(chip_oneshot_reset), .cpu_flash_reset(cpu_flash_reset));

`default_nettype wire

// ### testbench/rsc_reset_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none

module rsc_reset_ctrl_tb;
    import rsc_pkg::*;
    // Arbitrary identification value
    localparam logic [31:0] PID = 32'h0000_3c5a;
    logic clock, rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, pin_n, wd, lv, bo, sys;
    logic sysrst, xtal, chip, cpu, xbus, dma;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, periph, seed, d;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    int error_cnt, total_checks;

    rsc_reset_ctrl #(.PART_ID(PID)) i_rsc_reset_ctrl (
        .clock(clock), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .ext_pin_reset_n(pin_n), .watchdog_reset(wd), .low_voltage_reset(lv),
        .brownout_reset(bo), .core_sys_reset_request(sys), .system_reset(sysrst),
        .xtal_boot_reset(xtal), .chip_oneshot_reset(chip), .cpu_flash_reset(cpu),
        .ext_bus_if_reset(xbus), .periph_dma_reset(dma), .periph_reset(periph));

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Source order in the loop: watchdog, low voltage, brown-out, core request, pin
    function automatic logic [31:0] exp_cause(input int i);
        return 32'h1 << ((i < 4) ? i + 2 : 1);
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [1:0] er);
        logic ta, td;
        ta = 1'b0;
        td = 1'b0;
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(ta && td)) begin
            @(posedge clock);
            if (awvalid && awready) begin
                ta = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                td = 1'b1;
                wvalid <= 1'b0;
            end
        end
        bready <= 1'b1;
        do @(posedge clock); while (!bvalid);
        chk(32'(bresp), 32'(er));
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge clock); while (!arready);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do @(posedge clock); while (!rvalid);
        chk(rdata, e);
        chk(32'(rresp), 32'(er));
        rready <= 1'b0;
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // A hang costs a mismatch; the full run needs about 300 cycles
    initial begin
        repeat (20000) @(posedge clock);
        error_cnt++;
        wrap_up();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {rst_n, awvalid, wvalid, bready, arvalid, rready, wd, lv, bo, sys} = '0;
        pin_n = 1'b1;
        {awaddr, araddr, wdata} = '0;
        wstrb = 4'hf;
        seed = 32'h0000_0050;
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        rd(OFS_PART_ID, PID, RESP_OKAY);
        rd(OFS_CAUSE, 32'h1, RESP_OKAY);
        rd(OFS_CORE_CTL, 32'h0, RESP_OKAY);
        rd(OFS_PERIPH_CTL, 32'h0, RESP_OKAY);
        wr(OFS_PART_ID, 32'hffff_ffff, RESP_OKAY);
        rd(OFS_PART_ID, PID, RESP_OKAY);
        wr(12'h010, 32'h1, RESP_SLVERR);
        rd(12'h010, 32'h0, RESP_SLVERR);
        wr(OFS_CAUSE, 32'hffff_fffe, RESP_OKAY);
        rd(OFS_CAUSE, 32'h1, RESP_OKAY);
        wr(OFS_CAUSE, 32'h1, RESP_OKAY);
        rd(OFS_CAUSE, 32'h0, RESP_OKAY);
        for (int i = 0; i < 5; i++) begin
            d = 32'h1 << i;
            {sys, bo, lv, wd} <= d[3:0];
            pin_n <= !d[4];
            repeat (6) @(posedge clock);
            chk(32'({sysrst, xtal}), 32'h2);
            {sys, bo, lv, wd} <= 4'h0;
            pin_n <= 1'b1;
            repeat (4) @(posedge clock);
            rd(OFS_CAUSE, exp_cause(i), RESP_OKAY);
            wr(OFS_CAUSE, exp_cause(i), RESP_OKAY);
        end
        wr(OFS_CORE_CTL, 32'hc, RESP_OKAY);
        rd(OFS_CORE_CTL, 32'h0, RESP_OKAY);
        wr(OFS_UNLOCK, 32'h16, RESP_OKAY);
        wr(OFS_UNLOCK, 32'h88, RESP_OKAY);
        rd(OFS_UNLOCK, 32'h0, RESP_OKAY);
        wr(OFS_UNLOCK, 32'(UNLOCK_KEY0), RESP_OKAY);
        wr(OFS_UNLOCK, 32'(UNLOCK_KEY1), RESP_OKAY);
        wr(OFS_UNLOCK, 32'(UNLOCK_KEY2), RESP_OKAY);
        wr(OFS_CORE_CTL, 32'hc, RESP_OKAY);
        rd(OFS_CORE_CTL, 32'hc, RESP_OKAY);
        chk(32'({xbus, dma}), 32'h3);
        wr(OFS_CORE_CTL, 32'h0, RESP_OKAY);
        chk(32'({xbus, dma}), 32'h0);
        // Shot bits drop two cycles after the write acts, so look then
        wr(OFS_CORE_CTL, 32'h2, RESP_OKAY);
        chk(32'({chip, cpu}), 32'h1);
        repeat (2) @(posedge clock);
        chk(32'({chip, cpu, xtal, sysrst}), 32'h0);
        rd(OFS_CORE_CTL, 32'h0, RESP_OKAY);
        rd(OFS_CAUSE, 32'h80, RESP_OKAY);
        wr(OFS_CAUSE, 32'h80, RESP_OKAY);
        wr(OFS_CORE_CTL, 32'h1, RESP_OKAY);
        chk(32'({chip, cpu}), 32'h2);
        repeat (2) @(posedge clock);
        chk(32'({chip, cpu, xtal, sysrst}), 32'h3);
        rd(OFS_CORE_CTL, 32'h0, RESP_OKAY);
        rd(OFS_CAUSE, 32'h1, RESP_OKAY);
        for (int i = 0; i < 24; i++) begin
            d = (i == 0) ? 32'hffff_ffff : xs();
            wr(OFS_PERIPH_CTL, d, RESP_OKAY);
            rd(OFS_PERIPH_CTL, d & PERIPH_MASK, RESP_OKAY);
            chk(periph, d & PERIPH_MASK);
        end
        wstrb <= 4'h1;
        wr(OFS_PERIPH_CTL, 32'h0, RESP_OKAY);
        wstrb <= 4'hf;
        rd(OFS_PERIPH_CTL, d & PERIPH_MASK & 32'hffff_ff00, RESP_OKAY);
        wr(OFS_UNLOCK, 32'h0, RESP_OKAY);
        wr(OFS_CORE_CTL, 32'h8, RESP_OKAY);
        rd(OFS_CORE_CTL, 32'h0, RESP_OKAY);
        chk(32'(xbus), 32'h0);
        wrap_up();
    end
endmodule // rsc_reset_ctrl_tb

`default_nettype wire
